// ===== chc_defs.vh
// constants for the card host controller: register map, fields, modes and timing
`ifndef CHC_DEFS_VH
`define CHC_DEFS_VH

// register byte offsets
`define CHC_REG_CTRL 5'h00
`define CHC_REG_ADDR 5'h04
`define CHC_REG_DATA 5'h08
`define CHC_REG_CMD 5'h0C
`define CHC_REG_PINS 5'h10
`define CHC_REG_IRQ_STS 5'h14
`define CHC_REG_IRQ_MASK 5'h18

// control register fields
`define CHC_CTRL_MODE_LSB 0
`define CHC_CTRL_MODE_MSB 1
`define CHC_CTRL_RESET_BIT 2
`define CHC_CTRL_SLAVE_BIT 3
`define CHC_CTRL_WIDE_BIT 4
`define CHC_CTRL_RST_VAL 32'h0000_0004

// address register fields
`define CHC_ADDR_MSB 10
`define CHC_ADDR_SPACE_BIT 16

// command register fields
`define CHC_CMD_GO_BIT 0
`define CHC_CMD_WRITE_BIT 1
`define CHC_CMD_IO_BIT 2

// interrupt status bits
`define CHC_IRQ_DONE 0
`define CHC_IRQ_DETECT 1
`define CHC_IRQ_CARD 2
`define CHC_IRQ_STATUS_CHANGED_N 3
`define CHC_IRQ_W 4

// interface modes
`define CHC_MODE_MEM 2'h0
`define CHC_MODE_IO 2'h1
`define CHC_MODE_DISK 2'h2

// access timing
`define CHC_CLK_NS 5
`define CHC_SETUP_NS 30
`define CHC_STROBE_NS 80
`define CHC_HOLD_NS 20
`define CHC_SETUP_CYC ((`CHC_SETUP_NS + `CHC_CLK_NS - 1) / `CHC_CLK_NS)
`define CHC_STROBE_CYC ((`CHC_STROBE_NS + `CHC_CLK_NS - 1) / `CHC_CLK_NS)
`define CHC_HOLD_CYC ((`CHC_HOLD_NS + `CHC_CLK_NS - 1) / `CHC_CLK_NS)

`endif

// ===== chc_card_host.v
// host controller that drives a removable flash card over its parallel pins
`include "chc_defs.vh"

module chc_card_host (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// interrupt
	output reg irq_o,
	// card address, selects and strobes
	output reg [10:0] card_addr_o,
	output reg card_ce1_n_o,
	output reg card_ce2_n_o,
	output reg card_oe_n_o,
	output reg card_we_n_o,
	output reg io_read_n_o,
	output reg io_write_n_o,
	output reg card_reg_n_o,
	output reg card_reset_o,
	// card data bus
	input wire [15:0] card_data_i,
	output reg [15:0] card_data_o,
	output reg card_data_oe_o,
	// drive select, open drain
	input wire drive_select_n_i,
	output reg drive_select_n_o,
	output reg drive_select_oe_o,
	// card status pins
	input wire card_pin37_i,
	input wire card_pin42_i,
	input wire card_pin43_i,
	input wire card_pin45_i,
	input wire card_pin46_i,
	input wire detect_one_n_i,
	input wire detect_two_n_i
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_STROBE = 2'h2;
localparam ST_HOLD = 2'h3;
localparam [31:0] SETUP_N = `CHC_SETUP_CYC;
localparam [31:0] STROBE_N = `CHC_STROBE_CYC;
localparam [31:0] HOLD_N = `CHC_HOLD_CYC;
// the strobe count does not fit four bits, so the counter is five wide
localparam [4:0] SETUP_C = SETUP_N[4:0];
localparam [4:0] STROBE_C = STROBE_N[4:0];
localparam [4:0] HOLD_C = HOLD_N[4:0];

// byte-lane merge of a bus write
function [31:0] lane_merge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] sel;
	integer i;
	begin
		lane_merge = old_v;
		for (i = 0; i < 4; i = i + 1) begin
			if (sel[i])
				lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
		end
	end
endfunction

// strobe must stretch while the card asks to wait
function card_stall;
	input [1:0] mode;
	input pin42;
	begin
		if (mode == `CHC_MODE_DISK)
			card_stall = ~pin42;
		else
			card_stall = ~pin42;
	end
endfunction

// interrupt request level as seen on the shared pin
function card_irq;
	input [1:0] mode;
	input pin37;
	begin
		case (mode)
		`CHC_MODE_IO: card_irq = ~pin37;
		`CHC_MODE_DISK: card_irq = pin37;
		default: card_irq = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg [31:0] ctrl_reg;
reg [31:0] addr_reg;
reg [31:0] wdata_reg;
reg [15:0] rdata_reg;
reg [3:0] sts_reg;
reg [3:0] sts_next;
reg [3:0] mask_reg;
reg [1:0] mode_reg;
reg [1:0] state_reg;
reg [4:0] cnt_reg;
reg op_write_reg;
reg op_io_reg;
reg present_reg;
reg status_changed_n_seen_reg;

wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire bus_wr = bus_req & wb_we_i;
wire present = ~detect_one_n_i & ~detect_two_n_i;
wire is_disk = (mode_reg == `CHC_MODE_DISK);
wire wide = ctrl_reg[`CHC_CTRL_WIDE_BIT] | is_disk;
wire space = addr_reg[`CHC_ADDR_SPACE_BIT];
wire go = bus_wr & (wb_adr_i == `CHC_REG_CMD) & wb_sel_i[0] & wb_dat_i[`CHC_CMD_GO_BIT];
wire start = go & (state_reg == ST_IDLE) & present & ~ctrl_reg[`CHC_CTRL_RESET_BIT];
wire use_io = is_disk | (op_io_reg & (mode_reg == `CHC_MODE_IO));
wire [31:0] ctrl_wr = lane_merge(ctrl_reg, wb_dat_i, wb_sel_i);
wire access_done = (state_reg == ST_HOLD) & (cnt_reg == 5'h00);
wire status_changed_n = (mode_reg == `CHC_MODE_IO) & ~card_pin46_i;
wire [3:0] events;

assign events[`CHC_IRQ_DONE] = access_done;
assign events[`CHC_IRQ_DETECT] = present ^ present_reg;
assign events[`CHC_IRQ_CARD] = card_irq(mode_reg, card_pin37_i);
assign events[`CHC_IRQ_STATUS_CHANGED_N] = status_changed_n & ~status_changed_n_seen_reg;

////////////////////////////////////////////////////////////////////////////////
// interrupt status: a new event wins over a write-one clear
always @* begin
	sts_next = sts_reg | events;
	if (bus_wr && wb_adr_i == `CHC_REG_IRQ_STS && wb_sel_i[0])
		sts_next = (sts_reg & ~wb_dat_i[3:0]) | events;
end

////////////////////////////////////////////////////////////////////////////////
// register file and bus answer
always @(posedge clk_i) begin
	if (rst_i) begin
		ctrl_reg <= `CHC_CTRL_RST_VAL;
		addr_reg <= 32'h0000_0000;
		wdata_reg <= 32'h0000_0000;
		mask_reg <= 4'h0;
		sts_reg <= 4'h0;
		mode_reg <= `CHC_MODE_MEM;
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
		irq_o <= 1'b0;
		present_reg <= 1'b0;
		status_changed_n_seen_reg <= 1'b0;
	end else begin
		wb_ack_o <= bus_req;
		sts_reg <= sts_next;
		irq_o <= |(sts_next & mask_reg);
		present_reg <= present;
		status_changed_n_seen_reg <= status_changed_n;
		if (ctrl_reg[`CHC_CTRL_RESET_BIT])
			mode_reg <= ctrl_reg[`CHC_CTRL_MODE_MSB:`CHC_CTRL_MODE_LSB];
		if (bus_wr) begin
			case (wb_adr_i)
			`CHC_REG_CTRL: begin
				ctrl_reg[7:0] <= {3'h0, ctrl_wr[4:0]};
				if (!ctrl_reg[`CHC_CTRL_RESET_BIT])
					ctrl_reg[1:0] <= ctrl_reg[1:0];
			end
			`CHC_REG_ADDR: addr_reg <= lane_merge(addr_reg, wb_dat_i, wb_sel_i) & 32'h0001_07FF;
			`CHC_REG_DATA: wdata_reg <= lane_merge(wdata_reg, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
			`CHC_REG_IRQ_MASK: begin
				if (wb_sel_i[0])
					mask_reg <= wb_dat_i[3:0];
			end
			default: begin
			end
			endcase
		end
		if (bus_req) begin
			case (wb_adr_i)
			`CHC_REG_CTRL: wb_dat_o <= ctrl_reg;
			`CHC_REG_ADDR: wb_dat_o <= addr_reg;
			`CHC_REG_DATA: wb_dat_o <= {16'h0000, rdata_reg};
			`CHC_REG_CMD: wb_dat_o <= {31'h0000_0000, state_reg != ST_IDLE};
			`CHC_REG_PINS: wb_dat_o <= {22'h00_0000, mode_reg, drive_select_n_i,
				card_pin46_i, card_pin45_i, card_pin43_i, card_pin42_i,
				card_pin37_i, present_reg, present};
			`CHC_REG_IRQ_STS: wb_dat_o <= {28'h000_0000, sts_reg};
			`CHC_REG_IRQ_MASK: wb_dat_o <= {28'h000_0000, mask_reg};
			default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// card access sequencer and pin drive
always @(posedge clk_i) begin
	if (rst_i) begin
		state_reg <= ST_IDLE;
		cnt_reg <= 5'h00;
		op_write_reg <= 1'b0;
		op_io_reg <= 1'b0;
		rdata_reg <= 16'h0000;
		card_addr_o <= 11'h000;
		card_ce1_n_o <= 1'b1;
		card_ce2_n_o <= 1'b1;
		card_oe_n_o <= 1'b1;
		card_we_n_o <= 1'b1;
		io_read_n_o <= 1'b1;
		io_write_n_o <= 1'b1;
		card_reg_n_o <= 1'b1;
		card_reset_o <= 1'b1;
		card_data_o <= 16'h0000;
		card_data_oe_o <= 1'b0;
		drive_select_n_o <= 1'b0;
		drive_select_oe_o <= 1'b1;
	end else begin
		// reset pin is active low in disk mode
		card_reset_o <= is_disk ? ~ctrl_reg[`CHC_CTRL_RESET_BIT] :
			ctrl_reg[`CHC_CTRL_RESET_BIT];
		drive_select_n_o <= 1'b0;
		drive_select_oe_o <= ~(is_disk & ctrl_reg[`CHC_CTRL_SLAVE_BIT]);
		if (is_disk) begin
			card_we_n_o <= 1'b1;
			card_reg_n_o <= 1'b1;
			card_oe_n_o <= 1'b0;
		end
		case (state_reg)
		ST_IDLE: begin
			if (!is_disk)
				card_oe_n_o <= 1'b1;
			if (start) begin
				op_write_reg <= wb_dat_i[`CHC_CMD_WRITE_BIT];
				op_io_reg <= wb_dat_i[`CHC_CMD_IO_BIT];
				card_data_o <= wdata_reg[15:0];
				card_data_oe_o <= wb_dat_i[`CHC_CMD_WRITE_BIT];
				if (is_disk) begin
					card_addr_o <= {8'h00, addr_reg[2:0]};
					card_ce1_n_o <= space;
					card_ce2_n_o <= ~space;
				end else begin
					card_addr_o <= addr_reg[`CHC_ADDR_MSB:0];
					card_reg_n_o <= ~space;
					card_ce1_n_o <= 1'b0;
					card_ce2_n_o <= ~wide;
				end
				cnt_reg <= SETUP_C - 5'h01;
				state_reg <= ST_SETUP;
			end
		end
		ST_SETUP: begin
			if (cnt_reg == 5'h00) begin
				if (use_io) begin
					io_read_n_o <= op_write_reg;
					io_write_n_o <= ~op_write_reg;
				end else begin
					card_oe_n_o <= op_write_reg;
					card_we_n_o <= ~op_write_reg;
				end
				cnt_reg <= STROBE_C - 5'h01;
				state_reg <= ST_STROBE;
			end else begin
				cnt_reg <= cnt_reg - 5'h01;
			end
		end
		ST_STROBE: begin
			if (cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'h01;
			end else if (!card_stall(mode_reg, card_pin42_i)) begin
				if (!op_write_reg)
					rdata_reg <= wide ? card_data_i : {8'h00, card_data_i[7:0]};
				io_read_n_o <= 1'b1;
				io_write_n_o <= 1'b1;
				if (!is_disk) begin
					card_oe_n_o <= 1'b1;
					card_we_n_o <= 1'b1;
				end
				cnt_reg <= HOLD_C - 5'h01;
				state_reg <= ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (cnt_reg == 5'h00) begin
				card_ce1_n_o <= 1'b1;
				card_ce2_n_o <= 1'b1;
				card_data_oe_o <= 1'b0;
				if (!is_disk)
					card_reg_n_o <= 1'b1;
				state_reg <= ST_IDLE;
			end else begin
				cnt_reg <= cnt_reg - 5'h01;
			end
		end
		default: state_reg <= ST_IDLE;
		endcase
	end
end

endmodule

// ===== chc_props.sv
// checker of pin rules and bus answers of the card host controller
module chc_props (
	// clock, reset and bus
	input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
	// card pins
	input wire [10:0] card_addr_o,
	input wire card_ce1_n_o, card_ce2_n_o, card_oe_n_o, card_we_n_o, io_read_n_o,
	input wire card_reg_n_o, card_reset_o, drive_select_oe_o, detect_one_n_i, detect_two_n_i
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// a disk read is the only time oe and the io read strobe are low together
	wire disk_rd = !card_oe_n_o && !io_read_n_o;
	////////////////////
	sequence oe_start;
		$fell(card_oe_n_o);
	endsequence
	sequence absent;
		(detect_one_n_i || detect_two_n_i) [*8];
	endsequence
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer wrong");
	upper_addr_a: assert property (disk_rd |-> card_addr_o[10:3] == 8'h00)
		else $error("upper address set");
	no_dma_a: assert property (disk_rd |-> card_reg_n_o && card_we_n_o)
		else $error("tied pin low");
	one_select_a: assert property (disk_rd |-> card_ce1_n_o != card_ce2_n_o)
		else $error("select pair wrong");
	slave_disk_a: assert property (!drive_select_oe_o [*2] |-> !card_oe_n_o)
		else $error("drive select open");
	absent_idle_a: assert property (absent |-> card_ce1_n_o && card_ce2_n_o)
		else $error("enable while absent");
	reset_pins_a: assert property ($fell(rst_i) |-> card_reset_o && drive_select_oe_o)
		else $error("reset pins wrong");
	strobe_width_a: assert property (oe_start |=> !card_oe_n_o [*8])
		else $error("strobe too short");
endmodule
bind chc_card_host chc_props chc_props_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.card_addr_o, .card_ce1_n_o, .card_ce2_n_o, .card_oe_n_o, .card_we_n_o, .io_read_n_o,
	.card_reg_n_o, .card_reset_o, .drive_select_oe_o, .detect_one_n_i, .detect_two_n_i);

// ===== chc_card_model.sv
// behavioural flash card answering the host controller pins
module chc_card_model (
	// host side pins
	input wire clk_i,
	input wire [10:0] addr_i,
	input wire ce1_n_i, ce2_n_i, oe_n_i, rd_n_i, reg_n_i, sel_n_i, sel_oe_i,
	// bench controls
	input wire stall_i, chg_i,
	// card outputs
	output wire [15:0] data_o,
	output wire p37_o, p42_o, p45_o, p46_o, sel_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic disk_reg = 1'b0;
	logic [15:0] last_reg = 16'h0000;
	wire picked = !ce1_n_i || !ce2_n_i;
	wire rd = picked && (!rd_n_i || (!oe_n_i && !disk_reg));
	wire [15:0] val = disk_reg ? {ce1_n_i ? 8'h3c : 8'h5a, 5'h00, addr_i[2:0]}
		: {reg_n_i ? 5'h00 : 5'h1f, addr_i};
	////////////////////
	always @(posedge clk_i) begin
		if (!picked)
			disk_reg <= !oe_n_i;
		if (rd)
			last_reg <= val;
	end
	// a released bus shows the inverse of the last word
	assign data_o = rd ? val : ~last_reg;
	assign p37_o = !disk_reg;
	assign p42_o = !stall_i;
	assign p45_o = 1'b1;
	assign p46_o = disk_reg ? 1'b0 : !chg_i;
	assign sel_o = sel_oe_i ? sel_n_i : 1'b1;
endmodule

// ===== test_card_host_pin_mode_decode.sv
// self-checking bench for the card host controller
`include "chc_defs.vh"
module test_card_host_pin_mode_decode;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic detect_one_n_i = 1'b0;
	logic detect_two_n_i = 1'b0;
	logic stall = 1'b0;
	logic change = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	wire [31:0] wb_dat_o;
	wire [15:0] card_data_o, card_out, card_data_i;
	wire [10:0] card_addr_o;
	wire wb_ack_o, irq_o, card_ce1_n_o, card_ce2_n_o, card_oe_n_o, card_we_n_o, io_read_n_o;
	wire io_write_n_o, card_reg_n_o, card_reset_o, card_data_oe_o, drive_select_n_i;
	wire drive_select_n_o, drive_select_oe_o, card_pin37_i, card_pin42_i, card_pin45_i;
	wire card_pin46_i;
	wire card_pin43_i = card_pin37_i;
	wire [3:0] wb_sel_i = 4'hf;
	assign card_data_i = card_data_oe_o ? card_data_o : card_out;
	always #2.5 clk_i = ~clk_i;
	chc_card_host chc_card_host_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .card_addr_o, .card_ce1_n_o,
		.card_ce2_n_o, .card_oe_n_o, .card_we_n_o, .io_read_n_o, .io_write_n_o, .card_reg_n_o,
		.card_reset_o, .card_data_i, .card_data_o, .card_data_oe_o, .drive_select_n_i,
		.drive_select_n_o, .drive_select_oe_o, .card_pin37_i, .card_pin42_i, .card_pin43_i,
		.card_pin45_i, .card_pin46_i, .detect_one_n_i, .detect_two_n_i);
	chc_card_model chc_card_model_i (.clk_i, .addr_i(card_addr_o), .ce1_n_i(card_ce1_n_o),
		.ce2_n_i(card_ce2_n_o), .oe_n_i(card_oe_n_o), .rd_n_i(io_read_n_o),
		.reg_n_i(card_reg_n_o), .sel_n_i(drive_select_n_o), .sel_oe_i(drive_select_oe_o),
		.stall_i(stall), .chg_i(change), .data_o(card_out), .p37_o(card_pin37_i),
		.p42_o(card_pin42_i), .p45_o(card_pin45_i), .p46_o(card_pin46_i),
		.sel_o(drive_select_n_i));
	////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		// a missing answer counts as a mismatch
		if (wb_ack_o !== 1'b1)
			error_cnt++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q[15:0] & m, e);
	endtask
	// mode bits only take while the card reset bit is already set,
	// and the active mode follows them only while that bit stays set
	task automatic set_mode(input logic [31:0] m);
		wr(`CHC_REG_CTRL, m | 32'h0000_0004);
		wr(`CHC_REG_CTRL, m | 32'h0000_0004);
		wr(`CHC_REG_CTRL, m);
	endtask
	task automatic go(input logic [31:0] a, input logic [2:0] c);
		logic [31:0] q;
		int n = 0;
		wr(`CHC_REG_ADDR, a);
		wr(`CHC_REG_CMD, {29'h0000_0000, c});
		do begin
			bus(1'b0, `CHC_REG_CMD, 32'h0000_0000, q);
			n++;
		end while (q[0] !== 1'b0 && n < 40);
		if (q[0] !== 1'b0)
			error_cnt++;
	endtask
	task automatic t_mem();
		rc(`CHC_REG_CTRL, 16'hffff, 16'h0004);
		rc(5'h1c, 16'hffff, 16'h0000);
		set_mode(32'h0000_0010);
		wr(`CHC_REG_IRQ_MASK, 32'h0000_0001);
		go(32'h0001_0123, 3'h1);
		rc(`CHC_REG_DATA, 16'hffff, 16'hf923);
		rc(`CHC_REG_PINS, 16'h0361, 16'h0061);
		@(negedge clk_i);
		chk(irq_o, 1'b1);
		wr(`CHC_REG_IRQ_STS, 32'h0000_000f);
		rc(`CHC_REG_IRQ_STS, 16'h0001, 16'h0000);
		@(negedge clk_i);
		chk(irq_o, 1'b0);
		// narrow host: upper byte of the read word is dropped
		set_mode(32'h0000_0000);
		go(32'h0001_0123, 3'h1);
		rc(`CHC_REG_DATA, 16'hffff, 16'h0023);
	endtask
	task automatic t_io();
		set_mode(32'h0000_0011);
		@(posedge clk_i);
		change <= 1'b1;
		@(posedge clk_i);
		change <= 1'b0;
		rc(`CHC_REG_IRQ_STS, 16'h0008, 16'h0008);
		rc(`CHC_REG_PINS, 16'h0320, 16'h0120);
		stall <= 1'b1;
		fork
			go(32'h0000_0045, 3'h5);
			begin
				repeat (40) @(posedge clk_i);
				@(negedge clk_i);
				chk(io_read_n_o, 1'b0);
				@(posedge clk_i);
				stall <= 1'b0;
			end
		join
		rc(`CHC_REG_DATA, 16'hffff, 16'h0045);
		// io write parked in its strobe: write strobe low, data driven
		wr(`CHC_REG_DATA, 32'h0000_a5c3);
		stall <= 1'b1;
		fork
			go(32'h0000_0045, 3'h7);
			begin
				repeat (40) @(posedge clk_i);
				@(negedge clk_i);
				chk({io_write_n_o, io_read_n_o, card_data_oe_o}, 3'h3);
				chk(card_data_o, 16'ha5c3);
				@(posedge clk_i);
				stall <= 1'b0;
			end
		join
		chk(card_data_oe_o, 1'b0);
	endtask
	task automatic t_disk();
		set_mode(32'h0000_0002);
		go(32'h0000_0005, 3'h1);
		rc(`CHC_REG_DATA, 16'hffff, 16'h5a05);
		go(32'h0001_0006, 3'h1);
		rc(`CHC_REG_DATA, 16'hffff, 16'h3c06);
		rc(`CHC_REG_PINS, 16'h03fd, 16'h0229);
		set_mode(32'h0000_000a);
		rc(`CHC_REG_PINS, 16'h0380, 16'h0280);
		// mode bits written without the reset bit leave the active mode alone
		wr(`CHC_REG_CTRL, 32'h0000_0001);
		rc(`CHC_REG_PINS, 16'h0300, 16'h0200);
	endtask
	// one detect line high is not a seated card
	task automatic t_gone();
		wr(`CHC_REG_IRQ_STS, 32'h0000_000f);
		detect_two_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		go(32'h0000_0005, 3'h1);
		rc(`CHC_REG_IRQ_STS, 16'h0003, 16'h0002);
		rc(`CHC_REG_PINS, 16'h0001, 16'h0000);
	endtask
	task automatic close_out();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_mem();
		t_io();
		t_disk();
		t_gone();
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule
